/* File: rtl/scdc_top.sv */
// Purpose: divider, sync realignment, fine delay and soft reset control
// Assumes: register port writes and reads one byte per cycle, sync is a
//   synchronous pulse, channel select picks which channel a write hits
// Notes: analog effects appear only as control codes on outputs
`timescale 1ns/10ps

//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - divide sample clock by 1, 2, 4 or 8 from ratio register
// - valid sync input reloads divider with programmable state
// - sync honoured only when sync enable bit 7 is set
// - soft reset restarts datapath and clock generation logic
// - reset happens next cycle after write, then recovery interval
// - soft reset leaves all configuration registers unchanged
// - half-period phase offset enabled per channel by its register
// - fine delay enabled by low bit, eight-bit value per channel
// - delay code spans negative to positive limit in uniform steps
// - new fine delay applies at once, no commit step
// - setting fine delay enable triggers datapath reset
// - reference select chooses internal or external reference
// - range code selects 2.06 or 1.46 V full-scale span
// - full-scale code writable whichever reference is selected
// - sampling strobe on rising edge of divided clock
module scdc_top
  import scdc_pkg::*;
#(
  parameter int RECOVER_CYC = SCDC_RECOVER_CYC,
  parameter int NUM_CHAN = 2,
  // divider ratio field codes
  parameter logic [1:0] DIV_CODE_1 = 2'h0,
  parameter logic [1:0] DIV_CODE_2 = 2'h1,
  parameter logic [1:0] DIV_CODE_4 = 2'h2,
  parameter logic [1:0] DIV_CODE_8 = 2'h3,
  // sync reload value of the divider phase counter
  parameter logic [2:0] SYNC_LOAD = 3'h0,
  // bit of the phase register for channel 0; channel n uses this plus n
  parameter int HALF_PHASE_BIT0 = 0
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [NUM_CHAN-1:0] chan_sel,
  output logic [7:0] reg_rdata,
  input wire logic sync_in,
  output logic sample_strobe,
  output logic div_clk,
  output logic datapath_rst,
  output logic recovering,
  output logic ext_ref_sel,
  output logic [7:0] fs_range_code,
  output logic fs_wide,
  output scdc_chan_t [NUM_CHAN-1:0] chan_cfg
);

  typedef struct packed {
    scdc_regs_t regs;
    logic [NUM_CHAN-1:0][7:0] fd_val;
    logic [NUM_CHAN-1:0] fd_en;
    logic [NUM_CHAN-1:0] hp_en;
    scdc_state_t state;
    logic [31:0] rcv_cnt;
    logic [2:0] div_cnt;
    logic div_q;
    logic strobe;
    logic [7:0] rdata;
  } scdc_st_t;

  scdc_st_t st;
  scdc_st_t next_st;
  logic [2:0] div_mask;
  logic wr_reset;
  logic wr_fd_rise;
  logic sync_ok;

  //////////////////////////////////////////////////////////////////////////
  // rule 19 encodings: decode ratio to a counter wrap mask
  // parameterised encodings
  always_comb begin
    unique case (st.regs.div_ratio[1:0])
      DIV_CODE_1: div_mask = 3'h0;
      DIV_CODE_2: div_mask = 3'h1;
      DIV_CODE_4: div_mask = 3'h3;
      DIV_CODE_8: div_mask = 3'h7;
      default: div_mask = 3'h0;
    endcase
  end

  assign wr_reset = reg_wr && reg_addr == SCDC_OFF_SOFT_RESET &&
                    reg_wdata == SCDC_SOFT_RESET_CODE;
  assign wr_fd_rise = reg_wr && reg_addr == SCDC_OFF_FD_ENABLE &&
                      reg_wdata[SCDC_FD_EN_BIT] && !st.regs.fd_enable[SCDC_FD_EN_BIT];
  assign sync_ok = sync_in && st.regs.sync_ctrl[SCDC_SYNC_EN_BIT];

  //////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_st = st;
    next_st.strobe = 1'b0;
    if (reg_wr) begin
      unique case (reg_addr)
        SCDC_OFF_SOFT_RESET: next_st.regs.soft_reset = reg_wdata;
        SCDC_OFF_REF_SEL: next_st.regs.ref_sel = reg_wdata;
        SCDC_OFF_FS_RANGE: next_st.regs.fs_range = reg_wdata;
        SCDC_OFF_DIV_RATIO: next_st.regs.div_ratio = reg_wdata;
        SCDC_OFF_HALF_PHASE: next_st.regs.half_phase = reg_wdata;
        SCDC_OFF_SYNC_CTRL: next_st.regs.sync_ctrl = reg_wdata;
        SCDC_OFF_FD_ENABLE: next_st.regs.fd_enable = reg_wdata;
        SCDC_OFF_FD_VALUE: next_st.regs.fd_value = reg_wdata;
        default: ;
      endcase
    end
    for (int i = 0; i < NUM_CHAN; i++) begin
      if (reg_wr && chan_sel[i]) begin
        if (reg_addr == SCDC_OFF_FD_VALUE) begin
          next_st.fd_val[i] = reg_wdata;
        end
        if (reg_addr == SCDC_OFF_FD_ENABLE) begin
          next_st.fd_en[i] = reg_wdata[SCDC_FD_EN_BIT];
        end
        if (reg_addr == SCDC_OFF_HALF_PHASE) begin
          next_st.hp_en[i] = reg_wdata[HALF_PHASE_BIT0 + i];
        end
      end
    end
    if (reg_rd) begin
      unique case (reg_addr)
        SCDC_OFF_SOFT_RESET: next_st.rdata = st.regs.soft_reset;
        SCDC_OFF_REF_SEL: next_st.rdata = st.regs.ref_sel;
        SCDC_OFF_FS_RANGE: next_st.rdata = st.regs.fs_range;
        SCDC_OFF_DIV_RATIO: next_st.rdata = st.regs.div_ratio;
        SCDC_OFF_HALF_PHASE: next_st.rdata = st.regs.half_phase;
        SCDC_OFF_SYNC_CTRL: next_st.rdata = st.regs.sync_ctrl;
        SCDC_OFF_FD_ENABLE: next_st.rdata = st.regs.fd_enable;
        SCDC_OFF_FD_VALUE: next_st.rdata = st.regs.fd_value;
        default: next_st.rdata = 8'h00;
      endcase
    end
    // divider counter; strobe at wrap = rising edge
    if (st.div_cnt >= div_mask) begin
      next_st.div_cnt = 3'h0;
      next_st.strobe = st.state == SCDC_RUN;
    end else begin
      next_st.div_cnt = st.div_cnt + 3'h1;
    end
    next_st.div_q = next_st.div_cnt <= (div_mask >> 1);
    if (sync_ok) begin
      next_st.div_cnt = SYNC_LOAD & div_mask;
      next_st.strobe = 1'b0;
    end
    unique case (st.state)
      SCDC_RUN: begin
        // reset next cycle after the write
        if (wr_reset || wr_fd_rise) begin
          next_st.state = SCDC_RESET;
        end
      end
      SCDC_RESET: begin
        next_st.div_cnt = 3'h0;
        next_st.strobe = 1'b0;
        next_st.rcv_cnt = 32'h0;
        next_st.state = SCDC_RECOVER;
      end
      SCDC_RECOVER: begin
        // recovery interval; a new reset request restarts it
        if (wr_reset || wr_fd_rise) begin
          next_st.state = SCDC_RESET;
        end else if (st.rcv_cnt >= 32'(RECOVER_CYC - 1)) begin
          next_st.state = SCDC_RUN;
        end else begin
          next_st.rcv_cnt = st.rcv_cnt + 32'h1;
        end
      end
      default: next_st.state = SCDC_RUN;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st.regs <= '{soft_reset: SCDC_RST_SOFT_RESET, ref_sel: SCDC_RST_REF_SEL,
                   fs_range: SCDC_RST_FS_RANGE, div_ratio: SCDC_RST_DIV_RATIO,
                   half_phase: SCDC_RST_HALF_PHASE, sync_ctrl: SCDC_RST_SYNC_CTRL,
                   fd_enable: SCDC_RST_FD_ENABLE, fd_value: SCDC_RST_FD_VALUE};
      st.fd_val <= '0;
      st.fd_en <= '0;
      st.hp_en <= '0;
      st.state <= SCDC_RUN;
      st.rcv_cnt <= 32'h0;
      st.div_cnt <= 3'h0;
      st.div_q <= 1'b0;
      st.strobe <= 1'b0;
      st.rdata <= 8'h00;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  assign reg_rdata = st.rdata;
  assign sample_strobe = st.strobe;
  assign div_clk = st.div_q;
  assign datapath_rst = st.state == SCDC_RESET;
  assign recovering = st.state != SCDC_RUN;
  assign ext_ref_sel = st.regs.ref_sel[0];
  assign fs_range_code = st.regs.fs_range;
  assign fs_wide = st.regs.fs_range == SCDC_FS_WIDE;

  // raw code drives the delay line; 0 is the negative limit
  always_comb begin
    for (int i = 0; i < NUM_CHAN; i++) begin
      chan_cfg[i].fd_value = st.fd_val[i];
      chan_cfg[i].fd_enable = st.fd_en[i];
      chan_cfg[i].half_phase = st.hp_en[i];
    end
  end

endmodule

/* File: rtl/scdc_pkg.sv */
// Purpose: constants and types for the sample clock divider control block
// Assumes: 8-bit register port with 12-bit index, clock 50 MHz
// Notes: field encodings that are not fixed are module parameters
package scdc_pkg;
  localparam logic [11:0] SCDC_OFF_SOFT_RESET = 12'h001;
  localparam logic [11:0] SCDC_OFF_REF_SEL = 12'h024;
  localparam logic [11:0] SCDC_OFF_FS_RANGE = 12'h025;
  localparam logic [11:0] SCDC_OFF_DIV_RATIO = 12'h10b;
  localparam logic [11:0] SCDC_OFF_HALF_PHASE = 12'h10c;
  localparam logic [11:0] SCDC_OFF_SYNC_CTRL = 12'h10d;
  localparam logic [11:0] SCDC_OFF_FD_ENABLE = 12'h117;
  localparam logic [11:0] SCDC_OFF_FD_VALUE = 12'h118;
  localparam logic [7:0] SCDC_SOFT_RESET_CODE = 8'h02;
  localparam int SCDC_SYNC_EN_BIT = 7;
  localparam int SCDC_FD_EN_BIT = 0;
  localparam logic [7:0] SCDC_FS_WIDE = 8'h0c;
  localparam logic [7:0] SCDC_FS_NARROW = 8'h08;
  localparam logic [7:0] SCDC_RST_DIV_RATIO = 8'h00;
  localparam logic [7:0] SCDC_RST_HALF_PHASE = 8'h00;
  localparam logic [7:0] SCDC_RST_SYNC_CTRL = 8'h00;
  localparam logic [7:0] SCDC_RST_FD_ENABLE = 8'h00;
  localparam logic [7:0] SCDC_RST_FD_VALUE = 8'h00;
  localparam logic [7:0] SCDC_RST_REF_SEL = 8'h00;
  localparam logic [7:0] SCDC_RST_FS_RANGE = 8'h0c;
  localparam logic [7:0] SCDC_RST_SOFT_RESET = 8'h00;
  localparam int SCDC_CLK_MHZ = 50;
  localparam int SCDC_RECOVER_MS = 5;
  localparam int SCDC_RECOVER_CYC = SCDC_RECOVER_MS * 1000 * SCDC_CLK_MHZ;

  typedef enum logic [2:0] {
    SCDC_RUN = 3'b001,
    SCDC_RESET = 3'b010,
    SCDC_RECOVER = 3'b100
  } scdc_state_t;

  typedef struct packed {
    logic [7:0] soft_reset;
    logic [7:0] ref_sel;
    logic [7:0] fs_range;
    logic [7:0] div_ratio;
    logic [7:0] half_phase;
    logic [7:0] sync_ctrl;
    logic [7:0] fd_enable;
    logic [7:0] fd_value;
  } scdc_regs_t;

  typedef struct packed {
    logic [7:0] fd_value;
    logic fd_enable;
    logic half_phase;
  } scdc_chan_t;
endpackage

/* File: bench/scdc_props.sv */
// Purpose: port-level checks for scdc_top
// Assumes: clk_en held high by the bench
// Notes: bound into every scdc_top
`timescale 1ns/10ps
////////////////////////////////////////////////////////////
module scdc_props
  import scdc_pkg::*;
#(
  parameter int RECOVER_CYC = 20,
  parameter int NUM_CHAN = 2
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic reg_wr,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [NUM_CHAN-1:0] chan_sel,
  input wire logic sample_strobe,
  input wire logic datapath_rst,
  input wire logic recovering,
  input wire logic ext_ref_sel,
  input wire logic [7:0] fs_range_code,
  input wire logic fs_wide,
  input wire scdc_chan_t [NUM_CHAN-1:0] chan_cfg
);
  int rcnt;
  wire wr_go = reg_wr && clk_en;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // counts every cycle spent in reset plus recovery
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rcnt <= 0;
    end else if (datapath_rst) begin
      rcnt <= 1;
    end else if (recovering) begin
      rcnt <= rcnt + 1;
    end
  end
  AST_SR: assert property (
    wr_go && reg_addr == SCDC_OFF_SOFT_RESET && reg_wdata == SCDC_SOFT_RESET_CODE
    |=> datapath_rst) else $error("soft reset not started");
  AST_DPR: assert property (
    datapath_rst && clk_en && !reg_wr |=> !datapath_rst) else $error("reset pulse too long");
  AST_REC: assert property (
    datapath_rst |-> recovering) else $error("reset without recovery");
  AST_RECLEN: assert property (
    $fell(recovering) |-> rcnt >= RECOVER_CYC) else $error("recovery too short");
  AST_FS: assert property (
    fs_wide == (fs_range_code == SCDC_FS_WIDE)) else $error("range flag wrong");
  AST_REF: assert property (
    wr_go && reg_addr == SCDC_OFF_REF_SEL |=> ext_ref_sel == $past(reg_wdata[0]))
    else $error("reference select wrong");
  AST_STB: assert property (
    recovering && $past(recovering) |-> !sample_strobe) else $error("strobe in recovery");
  AST_CH: assert property (
    wr_go && reg_addr == SCDC_OFF_FD_VALUE && chan_sel[0]
    |=> chan_cfg[0].fd_value == $past(reg_wdata)) else $error("fine delay value wrong");
  cover property (datapath_rst);
  cover property (sample_strobe ##1 sample_strobe);
  cover property ($fell(recovering));
endmodule
bind scdc_top scdc_props #(.RECOVER_CYC(RECOVER_CYC), .NUM_CHAN(NUM_CHAN)) u_props(.ref_clk,
  .rst, .clk_en, .reg_wr, .reg_addr, .reg_wdata, .chan_sel, .sample_strobe, .datapath_rst,
  .recovering, .ext_ref_sel, .fs_range_code, .fs_wide, .chan_cfg);

/* File: bench/scdc_sync_src.sv */
// Purpose: external sync pulse source
// Assumes: one pulse per request
// Notes: line rests low between pulses
`timescale 1ns/10ps
////////////////////////////////////////////////////////////
module scdc_sync_src (
  input wire logic clk,
  input wire logic fire,
  output logic sync_in
);
  initial sync_in = 1'b0;
  always @(posedge clk) begin
    sync_in <= fire;
  end
endmodule

/* File: bench/scdc_tb.sv */
// Purpose: self-checking bench for scdc_top
// Assumes: recovery shortened to 20 cycles
// Notes: register reads are scored through a queue
`timescale 1ns/10ps
////////////////////////////////////////////////////////////
module tb;
  import scdc_pkg::*;
  localparam int RC = 20;
  logic ref_clk = 1'b0, rst = 1'b1, clk_en = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic fire = 1'b0, rd_seen = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, fs_range_code, v;
  logic [1:0] chan_sel = 2'h3;
  logic sync_in, sample_strobe, div_clk, datapath_rst, recovering, ext_ref_sel, fs_wide;
  scdc_chan_t [1:0] chan_cfg;
  logic [7:0] q[$];
  int err_total = 0, n_tests = 0, c;
  scdc_top #(.RECOVER_CYC(RC)) u_dut(.ref_clk, .rst, .clk_en, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .chan_sel, .reg_rdata, .sync_in, .sample_strobe, .div_clk, .datapath_rst,
    .recovering, .ext_ref_sel, .fs_range_code, .fs_wide, .chan_cfg);
  scdc_sync_src u_sync(.clk(ref_clk), .fire, .sync_in);
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] s = 2'h3);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    chan_sel <= s;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    q.push_back(e);
    @(posedge ref_clk);
    reg_rd <= 1'b0;
  endtask
  task automatic to_strobe();
    c = 0;
    do begin
      @(posedge ref_clk);
      #1;
      c++;
    end while (sample_strobe !== 1'b1 && c < 40);
  endtask
  always @(posedge ref_clk) begin
    if (rd_seen) chk("rdata", reg_rdata, q.pop_front());
    rd_seen <= reg_rd & clk_en;
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    #(20 * 4000);
    err_total++;
    end_of_test();
  end
  initial begin
    void'($urandom(32'hadff));
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    rd(SCDC_OFF_FS_RANGE, SCDC_RST_FS_RANGE);
    rd(12'h3ff, 8'h00);
    v = 8'($urandom);
    wr(SCDC_OFF_REF_SEL, v);
    #1 chk("ref", ext_ref_sel, v[0]);
    for (int i = 0; i < 2; i++) begin
      v = i ? SCDC_FS_WIDE : SCDC_FS_NARROW;
      wr(SCDC_OFF_FS_RANGE, v);
      #1 chk("fs_wide", fs_wide, i);
      chk("fs_code", fs_range_code, v);
      rd(SCDC_OFF_FS_RANGE, v);
    end
    $display("test regs done");
    for (int k = 0; k < 4; k++) begin
      wr(SCDC_OFF_DIV_RATIO, 8'(k));
      repeat (3) to_strobe();
      chk("period", c, 1 << k);
      chk("div_clk", div_clk, 1'b1);
    end
    $display("test divider done");
    wr(SCDC_OFF_HALF_PHASE, 8'h02, 2'h2);
    #1 chk("phase1", chan_cfg[1].half_phase, 1'b1);
    chk("phase0", chan_cfg[0].half_phase, 1'b0);
    v = 8'($urandom);
    wr(SCDC_OFF_FD_VALUE, v, 2'h1);
    #1 chk("fd1", chan_cfg[1].fd_value, 8'h00);
    chk("fd0", chan_cfg[0].fd_value, v);
    wr(SCDC_OFF_FD_ENABLE, 8'h01, 2'h1);
    #1 chk("fd_en", chan_cfg[0].fd_enable, 1'b1);
    chk("fd_rst", datapath_rst, 1'b1);
    c = 0;
    while (recovering === 1'b1 && c < 100) begin
      @(posedge ref_clk);
      #1;
      c++;
    end
    chk("recover", c >= RC && c <= RC + 2, 1'b1);
    wr(SCDC_OFF_SOFT_RESET, SCDC_SOFT_RESET_CODE);
    #1 chk("soft", datapath_rst, 1'b1);
    rd(SCDC_OFF_FD_VALUE, v);
    rd(SCDC_OFF_DIV_RATIO, 8'h03);
    repeat (RC + 4) @(posedge ref_clk);
    $display("test reset done");
    wr(SCDC_OFF_SYNC_CTRL, 8'h80);
    repeat (3) @(posedge ref_clk);
    fire <= 1'b1;
    @(posedge ref_clk);
    fire <= 1'b0;
    @(posedge ref_clk);
    to_strobe();
    chk("sync", c, 8);
    $display("test sync done");
    end_of_test();
  end
endmodule
